// *** pkg/irq_ack_pkg.sv ***
/*
 Constants shared by the interrupt acknowledge logic and its flag store.
 Assumes one CPU clock domain and 32 interrupt sources in two 16-bit halves.
*/
`default_nettype none
package irq_ack_pkg;
	localparam int unsigned NUM_IRQ = 32;
	localparam int unsigned HALF_W = 16;
	localparam logic [31:0] FLAGS_RESET = 32'h0000_0000;
	localparam logic [31:0] MASK_RESET = 32'h0000_0000;
	localparam logic [31:0] NMI_SOURCES = 32'h0000_0003;
	localparam logic [3:0] DETECT_PATTERN = 4'h8;
	localparam int unsigned SYNC_STAGES = 2;
	localparam int unsigned MIN_LOW_CYCLES = 3;
	localparam int unsigned CLK_PERIOD_NS = 100;
	localparam int unsigned ACK_LOW_CYCLES = 1;
endpackage
`default_nettype wire

// *** verilog/irq_flag_store.sv ***
/*
 Pending flags and enable masks of the interrupt unit.
 Assumes the acknowledge logic drives set, clear and write strobes per cycle.
*/
`timescale 1ns/10ps
`default_nettype none
module irq_flag_store #(
	parameter int unsigned N = irq_ack_pkg::NUM_IRQ
) (
	// clock and reset
	input  wire logic         clk_i,
	input  wire logic         reset_n_i,
	// flag control
	input  wire logic [N-1:0] flag_set_i,
	input  wire logic [N-1:0] flag_clr_i,
	input  wire logic         soft_reset_i,
	// mask writes
	input  wire logic         mask_we_i,
	input  wire logic [N-1:0] mask_wdata_i,
	input  wire logic         dbg_we_i,
	input  wire logic [N-1:0] dbg_wdata_i,
	// state out
	output logic      [N-1:0] flags_o,
	output logic      [N-1:0] mask_o,
	output logic      [N-1:0] dbg_mask_o
);
	typedef struct packed {
		logic [N-1:0] flags;
		logic [N-1:0] mask;
		logic [N-1:0] dbg;
	} store_t;
	store_t s_q;
	store_t s_d;

	always_comb begin
		s_d = s_q;
		// set beats clear so a request is not lost to a same-cycle clear; soft reset still drops it
		s_d.flags = (s_q.flags & ~flag_clr_i) | flag_set_i;
		if (soft_reset_i) begin
			s_d.flags = N'(irq_ack_pkg::FLAGS_RESET);
		end
		if (mask_we_i) begin
			s_d.mask = mask_wdata_i;
		end
		if (dbg_we_i) begin
			s_d.dbg = dbg_wdata_i;
		end
	end

	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
	end

	assign flags_o = s_q.flags;
	assign mask_o = s_q.mask;
	assign dbg_mask_o = s_q.dbg;
endmodule // irq_flag_store
`default_nettype wire

// *** verilog/interrupt_acknowledge_logic.sv ***
/*
 Interrupt acknowledge logic: synchronises external requests, holds pending
 flags, and pulses the active-low acknowledge on the first vector fetch.
 Assumes the core reports the vector fetch and the serviced source number.
*/
`timescale 1ns/10ps
`default_nettype none
// What this block does
// - acknowledge output marks an accepted interrupt with vector fetch on the address bus.
// - acknowledge goes low in the cycle after the first vector word fetch; that fetch clears the pending flag.
// - acknowledge is low for exactly one CPU clock per serviced interrupt.
// - a masked maskable interrupt gets no acknowledge and no branch.
// - pending flags record pending interrupts; enable masks gate maskable ones.
// - hardware reset clears flags, enable masks and debug masks to zero.
// - software reset clears only the pending flags.
// - external request detected on 1-0-0-0 falling-edge samples after two-stage sync.
module interrupt_acknowledge_logic #(
	parameter int unsigned N = irq_ack_pkg::NUM_IRQ,
	parameter int unsigned NEXT = 4
) (
	// clock and reset
	input  wire logic            clk_i,
	input  wire logic            reset_n_i,
	// request sources
	input  wire logic [NEXT-1:0] ext_irq_n_i,
	input  wire logic [N-1:0]    int_irq_i,
	// core side
	input  wire logic            vector_fetch_i,
	input  wire logic [4:0]      vector_num_i,
	input  wire logic            soft_reset_i,
	input  wire logic            mask_we_i,
	input  wire logic [N-1:0]    mask_wdata_i,
	input  wire logic            dbg_we_i,
	input  wire logic [N-1:0]    dbg_wdata_i,
	// outputs
	output logic                 irq_ack_strobe_n_o,
	output logic                 irq_taken_o,
	output logic [N-1:0]         pending_o,
	output logic [N-1:0]         enable_mask_o,
	output logic [N-1:0]         debug_critical_mask_o
);
	localparam int unsigned HW = irq_ack_pkg::HALF_W;

	// external lines land on sources 1..NEXT (nmi first)
	typedef struct packed {
		logic [NEXT-1:0] sync1;
		logic [NEXT-1:0] sync2;
		logic [NEXT-1:0][3:0] hist;
	} neg_t;
	neg_t n_q;
	neg_t n_d;

	typedef struct packed {
		logic ack_n;
	} pos_t;
	pos_t p_q;
	pos_t p_d;

	logic [NEXT-1:0] ext_det;
	logic [N-1:0]    set_vec;
	logic [N-1:0]    clr_vec;
	logic [N-1:0]    flags;
	logic [N-1:0]    mask;
	logic            allowed;

	// ==========================================
	// external request detection
	always_comb begin
		n_d = n_q;
		n_d.sync1 = ext_irq_n_i;
		n_d.sync2 = n_q.sync1;
		for (int i = 0; i < NEXT; i++) begin
			n_d.hist[i] = {n_q.hist[i][2:0], n_q.sync2[i]};
		end
	end

	// falling edge sampling keeps the decision half a cycle ahead of the core
	always_ff @(negedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			n_q <= '1;
		end else begin
			n_q <= n_d;
		end
	end

	genvar g;
	generate
		for (g = 0; g < NEXT; g++) begin : g_det
			// oldest sample high, then three low
			assign ext_det[g] = (n_q.hist[g] == irq_ack_pkg::DETECT_PATTERN);
		end
	endgenerate

	// one-cycle detect pulse: history shifts on, so the pattern lasts one cycle
	always_comb begin
		set_vec = int_irq_i;
		set_vec[NEXT:1] = int_irq_i[NEXT:1] | ext_det;
	end

	// ==========================================
	// acknowledge
	assign allowed = flags[vector_num_i]
		& (mask[vector_num_i] | irq_ack_pkg::NMI_SOURCES[vector_num_i]);

	always_comb begin
		clr_vec = '0;
		if (vector_fetch_i && allowed) begin
			clr_vec[vector_num_i] = 1'b1;
		end
	end

	always_comb begin
		p_d = p_q;
		// low only in the cycle after an accepted fetch, then high again
		p_d.ack_n = !(vector_fetch_i && allowed);
	end

	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			p_q <= '1;
		end else begin
			p_q <= p_d;
		end
	end

	irq_flag_store #(
		.N(N)
	) u_store (
		.clk_i        (clk_i),
		.reset_n_i    (reset_n_i),
		.flag_set_i   (set_vec),
		.flag_clr_i   (clr_vec),
		.soft_reset_i (soft_reset_i),
		.mask_we_i    (mask_we_i),
		.mask_wdata_i (mask_wdata_i),
		.dbg_we_i     (dbg_we_i),
		.dbg_wdata_i  (dbg_wdata_i),
		.flags_o      (flags),
		.mask_o       (mask),
		.dbg_mask_o   (debug_critical_mask_o)
	);

	assign irq_ack_strobe_n_o = p_q.ack_n;
	assign irq_taken_o = vector_fetch_i & allowed;
	assign pending_o = flags;
	assign enable_mask_o = mask;
endmodule // interrupt_acknowledge_logic
`default_nettype wire

// *** tb/irq_ack_sva.sv ***
/* Assertions on the acknowledge block ports.
 Assumes one clock, async active-low reset. */
`timescale 1ns/10ps
`default_nettype none
// ====
// checker
module irq_ack_sva (
	input wire logic	clk_i,
	input wire logic	reset_n_i,
	input wire logic	vector_fetch_i,
	input wire logic [4:0]	vector_num_i,
	input wire logic	soft_reset_i,
	input wire logic	mask_we_i,
	input wire logic [31:0]	mask_wdata_i,
	input wire logic	irq_ack_strobe_n_o,
	input wire logic	irq_taken_o,
	input wire logic [31:0]	pending_o,
	input wire logic [31:0]	enable_mask_o
);
	default clocking @(posedge clk_i); endclocking
	default disable iff (!reset_n_i);
	sequence ack_low;
		!irq_ack_strobe_n_o;
	endsequence
	ack_after_fetch_a: assert property (irq_taken_o |=> ack_low)
		else $error("no ack after fetch");
	ack_one_cycle_a: assert property (!irq_ack_strobe_n_o && !irq_taken_o |=> irq_ack_strobe_n_o)
		else $error("ack low too long");
	taken_pending_a: assert property (irq_taken_o |-> pending_o[vector_num_i])
		else $error("fetch taken without flag");
	masked_refuse_a: assert property (vector_fetch_i && vector_num_i > 5'h01
		&& !enable_mask_o[vector_num_i] |-> !irq_taken_o) else $error("masked fetch taken");
	soft_clear_a: assert property (soft_reset_i |=> pending_o == 32'h0000_0000)
		else $error("soft reset left flags");
	soft_keep_a: assert property (soft_reset_i && !mask_we_i |=> $stable(enable_mask_o))
		else $error("soft reset changed mask");
	mask_write_a: assert property (mask_we_i |=> enable_mask_o == $past(mask_wdata_i))
		else $error("mask not written");
	flag_hold_a: assert property (|($past(pending_o) & ~pending_o)
		|-> $past(irq_taken_o) || $past(soft_reset_i)) else $error("flag dropped");
endmodule // irq_ack_sva
bind interrupt_acknowledge_logic irq_ack_sva irq_ack_sva_i (.clk_i, .reset_n_i,
	.vector_fetch_i, .vector_num_i, .soft_reset_i, .mask_we_i, .mask_wdata_i,
	.irq_ack_strobe_n_o, .irq_taken_o, .pending_o, .enable_mask_o);
`default_nettype wire

// *** tb/core_model.sv ***
/* Core fetch model: one-cycle vector fetch a cycle after go.
 Assumes the bench pulses go for one cycle. */
`timescale 1ns/10ps
`default_nettype none
module core_model (
	input wire logic	clk_i,
	input wire logic	go_i,
	input wire logic [4:0]	num_i,
	output logic		vector_fetch_o = 1'b0,
	output logic [4:0]	vector_num_o = 5'h00
);
	// number scrambled outside a fetch so it cannot be relied on
	always_ff @(posedge clk_i) begin
		vector_fetch_o <= go_i;
		vector_num_o <= go_i ? num_i : ~vector_num_o;
	end
endmodule // core_model
`default_nettype wire

// *** tb/tb_top.sv ***
/* Self-checking bench for the acknowledge block.
 Assumes the core model drives fetches. */
`timescale 1ns/10ps
`default_nettype none
module tb_top;
	logic clk_i = 1'b0, reset_n_i = 1'b0, go = 1'b0, soft_reset_i = 1'b0;
	logic mask_we_i = 1'b0, dbg_we_i = 1'b0, vector_fetch_i, irq_ack_strobe_n_o, irq_taken_o;
	logic [3:0] ext_irq_n_i = 4'hF;
	logic [4:0] num = 5'h00, vector_num_i;
	logic [31:0] int_irq_i = 32'h0, mask_wdata_i = 32'h0, dbg_wdata_i = 32'h0;
	logic [31:0] pending_o, enable_mask_o, dbg_o;
	int n_fail = 0, check_count = 0, cyc = 0;
	// rows: source, enable, expected ack_n
	logic [6:0] rows [5] = '{7'h0A, 7'h7E, 7'h15, 7'h00, 7'h41};
	always #50 clk_i = ~clk_i;
	core_model core_model_i (.clk_i, .go_i(go), .num_i(num),
		.vector_fetch_o(vector_fetch_i), .vector_num_o(vector_num_i));
	interrupt_acknowledge_logic interrupt_acknowledge_logic_i (.clk_i, .reset_n_i,
		.ext_irq_n_i, .int_irq_i, .vector_fetch_i, .vector_num_i, .soft_reset_i,
		.mask_we_i, .mask_wdata_i, .dbg_we_i, .dbg_wdata_i, .irq_ack_strobe_n_o,
		.irq_taken_o, .pending_o, .enable_mask_o, .debug_critical_mask_o(dbg_o));
	task automatic chk(input string nm, input logic [31:0] seen, exp);
		check_count++;
		if (seen !== exp) begin
			n_fail++;
			$display("wrong value %s exp %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic end_of_test();
		$display("fails %0d checks %0d", n_fail, check_count);
		if (n_fail == 0 && check_count > 0) $display("ALL CHECKS OK");
		else $display("CHECKS NOT OK");
		$finish;
	endtask
	always @(posedge clk_i) begin
		cyc <= cyc + 1;
		if (cyc == 3000) begin
			n_fail++;
			end_of_test();
		end
	end
	initial begin
		repeat (8) @(posedge clk_i);
		reset_n_i <= 1'b1;
		@(posedge clk_i);
		#1 chk("rst ack_n", irq_ack_strobe_n_o, 1'b1);
		chk("rst flags", pending_o, 32'h0);
		foreach (rows[r]) begin
			@(posedge clk_i);
			mask_we_i <= 1'b1;
			mask_wdata_i <= 32'(rows[r][1]) << rows[r][6:2];
			int_irq_i <= 32'h1 << rows[r][6:2];
			@(posedge clk_i);
			mask_we_i <= 1'b0;
			int_irq_i <= 32'h0;
			go <= 1'b1;
			num <= rows[r][6:2];
			@(posedge clk_i);
			go <= 1'b0;
			@(posedge clk_i);
			#1 chk("ack_n", irq_ack_strobe_n_o, rows[r][0]);
			chk("flag", pending_o[rows[r][6:2]], rows[r][0]);
			@(posedge clk_i);
			#1 chk("ack_n back", irq_ack_strobe_n_o, 1'b1);
		end
		// shortest legal low pulse on the second external line
		@(posedge clk_i);
		ext_irq_n_i <= 4'hD;
		repeat (3) @(posedge clk_i);
		ext_irq_n_i <= 4'hF;
		repeat (3) @(posedge clk_i);
		#1 chk("ext flag", pending_o[2], 1'b1);
		mask_we_i <= 1'b1;
		dbg_we_i <= 1'b1;
		mask_wdata_i <= 32'hA5A5_0000;
		dbg_wdata_i <= 32'h0000_00FF;
		@(posedge clk_i);
		mask_we_i <= 1'b0;
		dbg_we_i <= 1'b0;
		soft_reset_i <= 1'b1;
		@(posedge clk_i);
		soft_reset_i <= 1'b0;
		@(posedge clk_i);
		chk("soft flags", pending_o, 32'h0);
		chk("soft mask", enable_mask_o, 32'hA5A5_0000);
		chk("soft dbg", dbg_o, 32'h0000_00FF);
		int_irq_i <= 32'h0000_0100;
		@(posedge clk_i);
		int_irq_i <= 32'h0;
		reset_n_i <= 1'b0;
		repeat (2) @(posedge clk_i);
		chk("hw mask", enable_mask_o, 32'h0);
		chk("hw dbg", dbg_o, 32'h0);
		chk("hw flags", pending_o, 32'h0);
		reset_n_i <= 1'b1;
		repeat (2) @(posedge clk_i);
		#1 chk("rel ack_n", irq_ack_strobe_n_o, 1'b1);
		chk("rel flags", pending_o, 32'h0);
		end_of_test();
	end
endmodule // tb_top
`default_nettype wire
